// File: design/clk_mode_pkg.sv
// Package: register map, field layout, reset values and carrier types of the clock mode block
package clk_mode_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_LOOP_POWER_POLARITY = 10'h010;
  localparam logic [ADDR_W-1:0] OFS_OSC_CALIBRATION     = 10'h018;
  localparam logic [ADDR_W-1:0] OFS_REFERENCE_ENABLE    = 10'h01c;
  localparam logic [ADDR_W-1:0] OFS_PRE_DIVIDER_RATIO   = 10'h1e0;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_ROUTE        = 10'h1e1;
  localparam logic [ADDR_W-1:0] OFS_UPDATE_STROBE       = 10'h232;
  localparam logic [ADDR_W-1:0] OFS_NVM_STORE           = 10'h2f0;
  localparam logic [ADDR_W-1:0] OFS_MODE_STATUS         = 10'h2f1;

  // Field positions
  localparam int PWR_LSB    = 0;
  localparam int POL_BIT    = 7;
  localparam int CAL_BIT    = 0;
  localparam int REF_LSB    = 0;
  localparam int RATIO_LSB  = 0;
  localparam int BYP_BIT    = 0;
  localparam int SRC_BIT    = 1;
  localparam int UPD_BIT    = 0;
  localparam int STORE_BIT  = 0;
  localparam int ST_NVM_BIT = 0;
  localparam int ST_LOOP_BIT = 1;
  localparam int ST_INT_BIT = 2;
  localparam int ST_CAL_BIT = 3;

  // Loop power codes
  localparam logic [1:0] PWR_NORMAL = 2'b00;
  localparam logic [1:0] PWR_DOWN   = 2'b01;

  // Pre-divider codes and ratios
  localparam logic [2:0] RATIO_CODE_DEFAULT = 3'h0;
  localparam logic [2:0] RATIO_DEFAULT      = 3'h2;
  localparam logic [2:0] RATIO_MIN          = 3'h1;
  localparam logic [2:0] RATIO_MAX          = 3'h6;

  // Reset values
  localparam logic [7:0] RST_LOOP_POWER_POLARITY = 8'h01;
  localparam logic [7:0] RST_OSC_CALIBRATION     = 8'h00;
  localparam logic [7:0] RST_REFERENCE_ENABLE    = 8'h00;
  localparam logic [7:0] RST_PRE_DIVIDER_RATIO   = 8'h00;
  localparam logic [7:0] RST_SOURCE_ROUTE        = 8'h00;
  localparam logic [7:0] RD_ZERO                 = 8'h00;

  // Software-visible configuration image
  typedef struct packed {
    logic [7:0] loop_power_polarity_ctrl;
    logic [7:0] osc_calibration_ctrl;
    logic [7:0] reference_input_enable;
    logic [7:0] pre_divider_ratio;
    logic [7:0] source_route_select;
  } cfg_type;

  localparam cfg_type CFG_RESET = '{
    loop_power_polarity_ctrl: RST_LOOP_POWER_POLARITY,
    osc_calibration_ctrl:     RST_OSC_CALIBRATION,
    reference_input_enable:   RST_REFERENCE_ENABLE,
    pre_divider_ratio:        RST_PRE_DIVIDER_RATIO,
    source_route_select:      RST_SOURCE_ROUTE
  };

  // Decoded controls toward the analog clock path
  typedef struct packed {
    logic       loop_on;
    logic       internal_osc_select;
    logic       divider_bypass;
    logic [2:0] prediv_ratio;
    logic       phase_detector_negative;
    logic       internal_osc_power;
    logic       external_to_prescaler;
    logic [2:0] reference_enable;
  } mode_type;

endpackage : clk_mode_pkg

// File: design/cfg_nvm_store.sv
// Nonvolatile image of the configuration, written on a store pulse
`timescale 1ns/10ps
module cfg_nvm_store #(
  parameter int IMG_W = 40
) (
  input  wire logic             core_clk,
  input  wire logic             por_n,
  input  wire logic             store,
  input  wire logic [IMG_W-1:0] image_in,
  output logic      [IMG_W-1:0] image_out,
  output logic                  image_valid
);

  logic [IMG_W-1:0] image_q;
  logic             valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cell contents survive chip reset; only the power-on reset input por_n clears validity
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      valid_q <= 1'b0;
    end else if (store) begin
      valid_q <= 1'b1;
    end
  end

  // Data cells carry no reset, as a real nonvolatile array would not
  always_ff @(posedge core_clk) begin
    if (store) begin
      image_q <= image_in;
    end
  end

  assign image_out   = image_q;
  assign image_valid = valid_q;

endmodule : cfg_nvm_store

// File: design/clock_source_mode_config.sv
// Clock source and mode configuration: staged and active registers, decode, calibration start
//
// Contract
// - After reset: loop powered down, external clock selected, routed through pre-divider.
// - Loop power field 00b runs the loop, 01b powers it down.
// - Source-select bit one picks internal oscillator, zero picks external input.
// - Bypass bit one feeds source directly, zero feeds it through pre-divider.
// - Polarity bit zero is positive phase detector polarity, one is negative.
// - Loop on with external source powers off internal oscillator, feeds prescaler.
// - Configuration can be saved to nonvolatile storage and restored after reset; power-on reset (por_n) discards it.
`timescale 1ns/10ps
module clock_source_mode_config (
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  input  wire logic                            por_n,
  input  wire logic [clk_mode_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clk_mode_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [clk_mode_pkg::DATA_W-1:0] reg_rdata,
  output clk_mode_pkg::mode_type               mode,
  output logic                                 cal_start
);
  import clk_mode_pkg::*;

  localparam int IMG_W = $bits(cfg_type);

  cfg_type          staged_q;
  cfg_type          staged_d;
  cfg_type          active_q;
  cfg_type          active_d;
  mode_type         mode_q;
  mode_type         mode_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic             restore_q;
  logic             cal_start_q;
  logic             cal_seen_q;
  logic [IMG_W-1:0] nvm_image;
  logic             nvm_valid;
  cfg_type          nvm_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Full-width compare; a short decode would alias into unmapped space
  wire hit_pwr    = (reg_addr == OFS_LOOP_POWER_POLARITY);
  wire hit_cal    = (reg_addr == OFS_OSC_CALIBRATION);
  wire hit_ref    = (reg_addr == OFS_REFERENCE_ENABLE);
  wire hit_ratio  = (reg_addr == OFS_PRE_DIVIDER_RATIO);
  wire hit_route  = (reg_addr == OFS_SOURCE_ROUTE);
  wire hit_upd    = (reg_addr == OFS_UPDATE_STROBE);
  wire hit_store  = (reg_addr == OFS_NVM_STORE);
  wire hit_status = (reg_addr == OFS_MODE_STATUS);

  // Update and store are self-clearing strobes, never held as state
  wire update_pulse = reg_wr && hit_upd && reg_wdata[UPD_BIT];
  wire store_pulse  = reg_wr && hit_store && reg_wdata[STORE_BIT];
  wire restore_now  = restore_q && nvm_valid;

  assign nvm_cfg = cfg_type'(nvm_image);

  ////////////////////////////////////////////////////////////////////////////
  // Staged registers: software writes land here and do nothing yet
  always_comb begin
    staged_d = staged_q;
    if (restore_now) begin
      staged_d = nvm_cfg;
    end else if (reg_wr) begin
      if (hit_pwr) begin
        staged_d.loop_power_polarity_ctrl = reg_wdata;
      end
      if (hit_cal) begin
        staged_d.osc_calibration_ctrl = reg_wdata;
      end
      if (hit_ref) begin
        staged_d.reference_input_enable = reg_wdata;
      end
      if (hit_ratio) begin
        staged_d.pre_divider_ratio = reg_wdata;
      end
      if (hit_route) begin
        staged_d.source_route_select = reg_wdata;
      end
    end
  end

  // Active registers follow the staged set only on an update
  always_comb begin
    active_d = active_q;
    if (restore_now) begin
      active_d = nvm_cfg;
    end else if (update_pulse) begin
      active_d = staged_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ratio decode: 1..6 pass as coded, 0 and the unused code give two
  // Unused code seven falls back to two rather than an undefined ratio
  function automatic logic [2:0] ratio_of(input logic [2:0] code);
    logic [2:0] r;
    r = RATIO_DEFAULT;
    if (code >= RATIO_MIN && code <= RATIO_MAX) begin
      r = code;
    end
    return r;
  endfunction : ratio_of

  // Decode of the active settings into clock path controls
  // Codes 10b and 11b also count as off; only 00b runs the loop
  wire [1:0] pwr_code  = active_q.loop_power_polarity_ctrl[PWR_LSB +: 2];
  wire       loop_on   = (pwr_code == PWR_NORMAL);
  wire       int_sel   = active_q.source_route_select[SRC_BIT];
  wire       cal_bit   = active_q.osc_calibration_ctrl[CAL_BIT];
  wire       cal_staged = staged_q.osc_calibration_ctrl[CAL_BIT];

  always_comb begin
    mode_d                         = mode_q;
    mode_d.loop_on                 = loop_on;
    mode_d.internal_osc_select     = int_sel;
    mode_d.divider_bypass          = active_q.source_route_select[BYP_BIT];
    mode_d.prediv_ratio            = ratio_of(active_q.pre_divider_ratio[RATIO_LSB +: 3]);
    mode_d.phase_detector_negative = active_q.loop_power_polarity_ctrl[POL_BIT];
    // Internal oscillator only draws power when it is the source and the loop runs
    mode_d.internal_osc_power      = loop_on && int_sel;
    mode_d.external_to_prescaler   = loop_on && !int_sel;
    mode_d.reference_enable        = active_q.reference_input_enable[REF_LSB +: 3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux: update strobe reads zero, unmapped offsets read zero
  // Reads return the staged copy, so software sees what it wrote
  // even before an update moves it into the clock path
  always_comb begin
    rdata_d = RD_ZERO;
    if (hit_pwr) begin
      rdata_d = staged_q.loop_power_polarity_ctrl;
    end else if (hit_cal) begin
      rdata_d = staged_q.osc_calibration_ctrl;
    end else if (hit_ref) begin
      rdata_d = staged_q.reference_input_enable;
    end else if (hit_ratio) begin
      rdata_d = staged_q.pre_divider_ratio;
    end else if (hit_route) begin
      rdata_d = staged_q.source_route_select;
    end else if (hit_status) begin
      rdata_d[ST_NVM_BIT]  = nvm_valid;
      rdata_d[ST_LOOP_BIT] = mode_q.loop_on;
      rdata_d[ST_INT_BIT]  = mode_q.internal_osc_select;
      rdata_d[ST_CAL_BIT]  = cal_seen_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration state; reset values give the plain distribution mode
  // Restore is armed by reset and taken on the first edge after release,
  // so a write on that same edge is lost when a stored image is valid;
  // software should leave one idle cycle after reset before writing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      staged_q  <= CFG_RESET;
      active_q  <= CFG_RESET;
      restore_q <= 1'b1;
    end else begin
      staged_q  <= staged_d;
      active_q  <= active_d;
      restore_q <= 1'b0; // Stored image is taken once, one edge after release
    end
  end

  // Registered outputs toward the clock path and the read port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= '0;
      rdata_q <= RD_ZERO;
    end else begin
      mode_q <= mode_d;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Calibration fires on a rising transfer of the bit, not on every update;
  // a repeated update with the bit still set would otherwise retune the loop
  // Restore never starts a calibration; software must retune after it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_start_q <= 1'b0;
      cal_seen_q  <= 1'b0;
    end else begin
      cal_start_q <= update_pulse && !restore_now && cal_staged && !cal_bit;
      if (cal_start_q) begin
        cal_seen_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile copy of the active configuration
  // Active set is saved, so a half-written staged set never lands in the image
  cfg_nvm_store #(
    .IMG_W (IMG_W)
  ) u_nvm (
    .core_clk    (core_clk),
    .por_n       (por_n),
    .store       (store_pulse),
    .image_in    (IMG_W'(active_q)),
    .image_out   (nvm_image),
    .image_valid (nvm_valid)
  );

  assign mode      = mode_q;
  assign reg_rdata = rdata_q;
  assign cal_start = cal_start_q;

endmodule : clock_source_mode_config

// File: verification/ext_clock_source.sv
// Model of the clock source that feeds the distribution path
`timescale 1ns/10ps
module ext_clock_source
  import clk_mode_pkg::*;
#(
  parameter int EXT_MHZ = 2400,
  parameter int INT_MHZ = 2800
) (
  input  wire clk_mode_pkg::mode_type mode,
  output int                          chan_mhz
);
  int src_mhz;
  int div;
  // Frequency seen by the channel dividers; code 0 only appears in reset
  assign src_mhz  = mode.internal_osc_select ? INT_MHZ : EXT_MHZ;
  assign div      = (mode.prediv_ratio == 3'h0) ? 1 : int'(mode.prediv_ratio);
  assign chan_mhz = mode.divider_bypass ? src_mhz : src_mhz / div;
endmodule : ext_clock_source

// File: verification/clock_source_mode_config_assertions.sv
// Checker of port relations of the clock mode block
`timescale 1ns/10ps
module clock_source_mode_config_assertions
  import clk_mode_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              por_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire mode_type          mode,
  input wire logic              cal_start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] age_q;
  wire        upd_w = reg_wr && reg_addr == OFS_UPDATE_STROBE && reg_wdata[UPD_BIT];
  // Edges since release; mode only settles after the restore cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  sequence store_s;
    reg_wr && reg_addr == OFS_NVM_STORE && reg_wdata[STORE_BIT];
  endsequence
  sequence stat_rd_s;
    reg_rd && reg_addr == OFS_MODE_STATUS;
  endsequence
  ////////////////////////////////////////////////////////////////
  osc_power_a: assert property (
    mode.internal_osc_power == (mode.loop_on && mode.internal_osc_select))
    else $error("internal oscillator power wrong");
  ext_feed_a: assert property (
    mode.external_to_prescaler == (mode.loop_on && !mode.internal_osc_select))
    else $error("external feed wrong");
  ratio_range_a: assert property (
    age_q != 2'h0 |-> mode.prediv_ratio inside {[RATIO_MIN:RATIO_MAX]})
    else $error("ratio out of range");
  cal_pulse_a: assert property (cal_start |=> !cal_start)
    else $error("calibration start too long");
  cal_cause_a: assert property (cal_start |-> $past(upd_w))
    else $error("calibration start without update");
  mode_hold_a: assert property (age_q == 2'h3 && !$stable(mode) |-> $past(upd_w, 2))
    else $error("mode changed without update");
  // Status is captured from the mode seen at the read edge, not the one after
  status_a: assert property (
    stat_rd_s |=> reg_rdata[ST_LOOP_BIT] == $past(mode.loop_on))
    else $error("status loop bit wrong");
  nvm_valid_a: assert property (store_s ##[1:2] stat_rd_s |=> reg_rdata[ST_NVM_BIT])
    else $error("stored image not valid");
endmodule : clock_source_mode_config_assertions

// File: verification/clock_source_mode_config_bench.sv
// Self-checking bench of the clock source mode block
`timescale 1ns/10ps
module clock_source_mode_config_bench;
  import clk_mode_pkg::*;
  logic              core_clk, rst_n, por_n, reg_wr, reg_rd, cal_start;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  mode_type          mode;
  int                miscompares, checks_done, cal_seen, chan_mhz;

  clock_source_mode_config u_dut (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode(mode), .cal_start(cal_start));
  ext_clock_source u_src (.mode(mode), .chan_mhz(chan_mhz));

  // 250 MHz clock and calibration pulse counter
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Sampled mid-cycle, where the registered pulse has settled
  always @(negedge core_clk) if (cal_start === 1'b1) cal_seen++;
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [11:0] got, input logic [11:0] want);
    checks_done++;
    if (got !== want) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask : cmp
  task automatic rst;
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    por_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : rst
  // One idle cycle after each strobe keeps drivers race free
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
    @(posedge core_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] want);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    @(posedge core_clk);
    #1 cmp({4'h0, reg_rdata}, {4'h0, want});
  endtask : rd
  task automatic upd;
    wr(OFS_UPDATE_STROBE, 8'h01);
    @(posedge core_clk);
    #1;
  endtask : upd
  task automatic cfg(input logic [1:0] p, input logic n, s, b, input logic [2:0] c);
    wr(OFS_LOOP_POWER_POLARITY, {n, 5'h00, p});
    wr(OFS_SOURCE_ROUTE, {6'h00, s, b});
    wr(OFS_PRE_DIVIDER_RATIO, {5'h00, c});
    wr(OFS_REFERENCE_ENABLE, {5'h00, c});
    upd;
  endtask : cfg
  function automatic mode_type em(input logic [1:0] p, input logic n, s, b, input logic [2:0] c);
    mode_type m;
    m.loop_on = (p == PWR_NORMAL);
    m.internal_osc_select = s;
    m.divider_bypass = b;
    m.prediv_ratio = (c == 3'h0 || c == 3'h7) ? RATIO_DEFAULT : c;
    m.phase_detector_negative = n;
    m.internal_osc_power = m.loop_on & s;
    m.external_to_prescaler = m.loop_on & ~s;
    m.reference_enable = c;
    return m;
  endfunction : em
  task automatic stop_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, por_n, reg_wr, reg_rd} = 4'h0;
    reg_addr = '0;
    reg_wdata = '0;
    rst;
    cmp(mode, em(PWR_DOWN, 1'b0, 1'b0, 1'b0, 3'h0));
    rd(OFS_LOOP_POWER_POLARITY, 8'h01);
    rd(OFS_SOURCE_ROUTE, 8'h00);
    rd(10'h3ff, 8'h00);
    cmp({11'h0, chan_mhz <= 1600}, 12'h001);
    for (int i = 0; i < 8; i++) begin
      cfg(i[1:0], i[0], i[2], i[1], i[2:0]);
      cmp(mode, em(i[1:0], i[0], i[2], i[1], i[2:0]));
    end
    wr(OFS_OSC_CALIBRATION, 8'h01);
    upd;
    upd;
    cmp(cal_seen[11:0], 12'h001);
    wr(OFS_OSC_CALIBRATION, 8'h00);
    upd;
    wr(OFS_OSC_CALIBRATION, 8'h01);
    upd;
    cmp(cal_seen[11:0], 12'h002);
    rd(OFS_MODE_STATUS, 8'h0c);
    cfg(2'h0, 1'b1, 1'b0, 1'b0, 3'h5);
    wr(OFS_NVM_STORE, 8'h01);
    rd(OFS_MODE_STATUS, 8'h0b);
    rst;
    cmp(mode, em(2'h0, 1'b1, 1'b0, 1'b0, 3'h5));
    cmp({11'h0, chan_mhz <= 2000}, 12'h001);
    por_n = 1'b0;
    rst;
    cmp(mode, em(PWR_DOWN, 1'b0, 1'b0, 1'b0, 3'h0));
    stop_test;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stop_test;
  end
endmodule : clock_source_mode_config_bench

bind clock_source_mode_config clock_source_mode_config_assertions u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mode(mode), .cal_start(cal_start));
